// *** rtl/canm_filter_buffers.sv ***
`default_nettype none
module canm_filter_buffers (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // received frame from the protocol engine
    input wire logic rx_frame_valid,
    input wire logic [31:0] rx_ident,
    input wire logic [63:0] rx_payload,
    input wire logic [3:0] rx_length,
    // transmit side toward the protocol engine
    input wire logic tx_done,
    output logic tx_request,
    output logic [31:0] tx_ident,
    output logic [63:0] tx_payload,
    output logic [3:0] tx_length,
    output logic [7:0] tx_priority_out,
    // status
    output logic rx_full_out
);
    // registers
    logic init_request;
    logic init_acknowledge;
    logic stamp_enable;
    logic rx_full_flag;
    logic tx_empty_flag;
    logic [7:0] tx_buffer_select;
    logic [7:0] tx_priority;
    logic [7:0] accept_code_reg [8];
    logic [7:0] accept_mask_reg [8];
    logic [15:0] stamp_timer;
    // ram-like storage, deliberately unreset, plus the reset new-frame flag
    logic [7:0] rx_bg [canm_pkg::MSG_BYTES];
    logic [7:0] rx_fg [canm_pkg::BUF_BYTES];
    logic [7:0] tx_buf [canm_pkg::BUF_BYTES];
    logic bg_new;

    // bus holding state
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // write path decode
    logic aw_take;
    logic w_take;
    logic wr_go;
    logic next_aw_full;
    logic next_w_full;
    logic next_bvalid;
    logic [5:0] wr_idx;
    logic [7:0] wr_byte;
    logic wr_lane;
    logic in_init;
    logic tx_access;
    logic wr_ctrl;
    logic wr_status;
    logic wr_sel;
    logic wr_filter;
    logic wr_rx;
    logic wr_tx;
    logic wr_mapped;
    logic [2:0] wr_fidx;
    logic wr_code_ok;
    logic wr_mask_ok;
    logic wr_tx_ok;
    logic wr_prio_ok;
    logic clr_rxf;
    logic clr_txe;

    assign aw_take = awvalid & awready;
    assign w_take = wvalid & wready;
    assign wr_go = aw_full & w_full & ~bvalid;
    assign next_aw_full = (aw_full | aw_take) & ~wr_go;
    assign next_w_full = (w_full | w_take) & ~wr_go;
    assign next_bvalid = wr_go | (bvalid & ~bready);
    assign wr_idx = aw_addr_q[7:2];
    assign wr_byte = w_data_q[7:0];
    assign wr_lane = wr_go & w_strb_q[0];
    assign in_init = init_request & init_acknowledge; // RL4
    assign tx_access = tx_empty_flag & tx_buffer_select[canm_pkg::SEL_TX0_BIT]; // RL15
    assign wr_ctrl = wr_idx == canm_pkg::IDX_CTRL;
    assign wr_status = wr_idx == canm_pkg::IDX_STATUS;
    assign wr_sel = wr_idx == canm_pkg::IDX_TXSEL;
    assign wr_filter = wr_idx[5:4] == canm_pkg::GRP_FILTER;
    assign wr_rx = wr_idx[5:4] == canm_pkg::GRP_RXBUF;
    assign wr_tx = wr_idx[5:4] == canm_pkg::GRP_TXBUF;
    assign wr_mapped = wr_ctrl | wr_status | wr_sel | wr_filter | wr_rx | wr_tx;
    assign wr_fidx = {wr_idx[3], wr_idx[1:0]};
    assign wr_code_ok = wr_lane & wr_filter & ~wr_idx[2] & in_init; // RL4
    assign wr_mask_ok = wr_lane & wr_filter & wr_idx[2] & in_init; // RL4
    // stamp bytes and priority slot excluded from plain buffer writes
    assign wr_tx_ok = wr_lane & wr_tx & tx_access
        & (wr_idx[3:0] < canm_pkg::OFS_PRIO); // RL10 RL15
    assign wr_prio_ok = wr_lane & wr_tx & tx_access
        & (wr_idx[3:0] == canm_pkg::OFS_PRIO); // RL8
    assign clr_rxf = wr_lane & wr_status & wr_byte[canm_pkg::STAT_RXF_BIT];
    assign clr_txe = wr_lane & wr_status & wr_byte[canm_pkg::STAT_TXE_BIT];

    // read path decode
    logic ar_take;
    logic [5:0] rd_idx;
    logic [7:0] rd_byte;
    logic rd_mapped;
    logic [2:0] rd_fidx;
    logic [7:0] rd_filter;
    logic [7:0] rd_rx;
    logic [7:0] rd_tx;
    logic [7:0] rd_status;

    assign ar_take = arvalid & arready;
    assign rd_idx = araddr[7:2];
    assign rd_fidx = {rd_idx[3], rd_idx[1:0]};
    assign rd_filter = rd_idx[2] ? accept_mask_reg[rd_fidx] : accept_code_reg[rd_fidx]; // RL4 RL5
    // receive buffer hidden while no frame is held
    assign rd_rx = rx_full_flag ? rx_fg[rd_idx[3:0]] : 8'h00; // RL16 RL12
    assign rd_tx = ~tx_access ? 8'h00 :
        (rd_idx[3:0] == canm_pkg::OFS_PRIO) ? tx_priority : tx_buf[rd_idx[3:0]]; // RL15 RL8
    assign rd_status = {5'h00, tx_empty_flag, rx_full_flag, init_acknowledge};
    assign rd_mapped = (rd_idx == canm_pkg::IDX_CTRL) | (rd_idx == canm_pkg::IDX_STATUS)
        | (rd_idx == canm_pkg::IDX_TXSEL) | (rd_idx[5:4] != 2'h0);
    assign rd_byte = (rd_idx == canm_pkg::IDX_CTRL) ?
        {4'h0, stamp_enable, 2'h0, init_request} :
        (rd_idx == canm_pkg::IDX_STATUS) ? rd_status :
        (rd_idx == canm_pkg::IDX_TXSEL) ? tx_buffer_select :
        (rd_idx[5:4] == canm_pkg::GRP_FILTER) ? rd_filter :
        (rd_idx[5:4] == canm_pkg::GRP_RXBUF) ? rd_rx :
        (rd_idx[5:4] == canm_pkg::GRP_TXBUF) ? rd_tx : 8'h00;

    // acceptance filter, one bank per generate pass
    logic [3:0] byte_ok [2];
    logic [1:0] bank_hit;
    logic frame_ext;
    logic accept;

    assign frame_ext = rx_bg[canm_pkg::OFS_IDENT1][canm_pkg::IDE_BIT];
    genvar gb, gk;
    generate
        for (gb = 0; gb < 2; gb++) begin : g_bank
            for (gk = 0; gk < 4; gk++) begin : g_byte
                // mask bit set lets that bit position disagree
                assign byte_ok[gb][gk] = &(~(accept_code_reg[4 * gb + gk] ^ rx_bg[gk])
                    | accept_mask_reg[4 * gb + gk]); // RL1 RL3
            end
            // standard frames only look at the first two bytes
            assign bank_hit[gb] = byte_ok[gb][0] & byte_ok[gb][1]
                & (~frame_ext | (byte_ok[gb][2] & byte_ok[gb][3])); // RL2 RL17
        end
    endgenerate
    assign accept = bg_new & (|bank_hit) & ~rx_full_flag; // RL2 RL18

    // bus channel flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= canm_pkg::RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rresp <= canm_pkg::RESP_OKAY;
            rdata <= 32'h0000_0000;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            awready <= ~next_aw_full & ~next_bvalid;
            wready <= ~next_w_full & ~next_bvalid;
            bvalid <= next_bvalid;
            if (wr_go) begin
                bresp <= wr_mapped ? canm_pkg::RESP_OKAY : canm_pkg::RESP_SLVERR;
            end
            arready <= ~(ar_take | (rvalid & ~rready));
            if (ar_take) begin
                rvalid <= 1'b1;
                rdata <= {24'h00_0000, rd_byte};
                rresp <= rd_mapped ? canm_pkg::RESP_OKAY : canm_pkg::RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (aw_take) begin
            aw_addr_q <= awaddr;
        end
        if (w_take) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end
    end

    // control, flags and filter registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_request <= 1'b0;
            init_acknowledge <= 1'b0;
            stamp_enable <= 1'b0;
            rx_full_flag <= 1'b0;
            tx_empty_flag <= canm_pkg::TXE_RESET;
            tx_buffer_select <= canm_pkg::TXSEL_RESET;
            tx_priority <= canm_pkg::PRIO_RESET; // RL8 RL11
            stamp_timer <= 16'h0000;
            bg_new <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                accept_code_reg[i] <= canm_pkg::FILTER_RESET;
                accept_mask_reg[i] <= canm_pkg::FILTER_RESET; // RL5
            end
        end else begin
            // acknowledge trails the request by one cycle
            init_acknowledge <= init_request;
            stamp_timer <= stamp_timer + 16'h0001;
            bg_new <= rx_frame_valid;
            if (wr_lane & wr_ctrl) begin
                init_request <= wr_byte[canm_pkg::CTRL_INIT_REQUEST_BIT];
                stamp_enable <= wr_byte[canm_pkg::CTRL_TIME_BIT];
            end
            if (wr_lane & wr_sel) begin
                tx_buffer_select <= {7'h00, wr_byte[canm_pkg::SEL_TX0_BIT]};
            end
            if (wr_prio_ok) begin
                tx_priority <= wr_byte; // RL8
            end
            // a hardware set in the clear cycle wins
            rx_full_flag <= accept | (rx_full_flag & ~clr_rxf); // RL18
            tx_empty_flag <= tx_done | (tx_empty_flag & ~clr_txe);
            if (wr_code_ok) begin
                accept_code_reg[wr_fidx] <= wr_byte; // RL4
            end
            if (wr_mask_ok) begin
                accept_mask_reg[wr_fidx] <= wr_byte; // RL4 RL5
            end
        end
    end

    // buffer storage, no reset: contents start undefined
    always_ff @(posedge aclk) begin
        if (rx_frame_valid) begin
            // background buffer is refilled by every frame, kept or not
            for (int k = 0; k < 4; k++) begin
                rx_bg[k] <= rx_ident[31 - 8 * k -: 8]; // RL13 RL14 RL18
            end
            for (int k = 0; k < 8; k++) begin
                rx_bg[4 + k] <= rx_payload[63 - 8 * k -: 8]; // RL7
            end
            rx_bg[canm_pkg::OFS_LENGTH] <= {4'h0, rx_length}; // RL13
        end
        if (accept) begin
            for (int k = 0; k < canm_pkg::MSG_BYTES; k++) begin
                rx_fg[k] <= rx_bg[k]; // RL6 RL7
            end
            if (stamp_enable) begin
                rx_fg[canm_pkg::OFS_STAMP_HI] <= stamp_timer[15:8]; // RL9
                rx_fg[canm_pkg::OFS_STAMP_LO] <= stamp_timer[7:0]; // RL9
            end
        end
        if (wr_tx_ok) begin
            tx_buf[wr_idx[3:0]] <= wr_byte; // RL6 RL7
        end
        if (tx_done & stamp_enable) begin
            tx_buf[canm_pkg::OFS_STAMP_HI] <= stamp_timer[15:8]; // RL9 RL10
            tx_buf[canm_pkg::OFS_STAMP_LO] <= stamp_timer[7:0]; // RL9 RL10
        end
    end

    // outward view of the transmit buffer and the receive full flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_request <= 1'b0;
            rx_full_out <= 1'b0;
            tx_ident <= 32'h0000_0000;
            tx_payload <= 64'h0000_0000_0000_0000;
            tx_length <= 4'h0;
            tx_priority_out <= canm_pkg::PRIO_RESET;
        end else begin
            tx_request <= ~tx_empty_flag & ~tx_done;
            rx_full_out <= rx_full_flag;
            tx_ident <= {tx_buf[0], tx_buf[1], tx_buf[2], tx_buf[3]};
            tx_payload <= {tx_buf[4], tx_buf[5], tx_buf[6], tx_buf[7],
                tx_buf[8], tx_buf[9], tx_buf[10], tx_buf[11]};
            tx_length <= tx_buf[canm_pkg::OFS_LENGTH][3:0];
            tx_priority_out <= tx_priority;
        end
    end
endmodule
`default_nettype wire

// *** rtl/canm_pkg.sv ***
// Summary of operation
// RL1 - clear mask bit: code bit must equal received identifier bit to match
// RL2 - accept only when every unmasked identifier bit equals its code bit
// RL3 - set mask bit: that code bit and identifier bit are ignored
// RL4 - masks readable anytime; writes land only while init request and acknowledge
// RL5 - second mask bank at indices 0x1c..0x1f, all zero after reset
// RL6 - receive and transmit buffers share one 16-byte layout, 13-byte message
// RL7 - ident 0..3, payload 4..0xb, length 0xc, priority 0xd, stamp 0xe/0xf
// RL8 - priority byte only in transmit buffer, zero after reset
// RL9 - with stamp enable, timer value captured after each good transfer
// RL10 - stamp bytes written by hardware only; software reads them
// RL11 - buffer contents unreset RAM, except the priority byte
// RL12 - unused buffer bits, length upper nibble included, read as stored junk; receive buffer length upper nibble is written as zero here, so it reads zero
// RL13 - extended ident layout: id28..21, id20..18/srr/ide/id17..15, id14..7, id6..0/rtr
// RL14 - standard ident layout: id10..3, then id2..0, rtr, ide in bits 7..3
// RL15 - transmit buffer access only while empty flag set and buffer selected
// RL16 - receive buffer read only while full flag set; writes ignored
// RL17 - extended frames use all four filter bytes, standard only first two
// RL18 - rejected frames not signalled and overwritten by next frame
`default_nettype none
package canm_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_TXSEL = 6'h02;
    localparam logic [5:0] IDX_CODE_B1 = 6'h10;
    localparam logic [5:0] IDX_MASK_B1 = 6'h14;
    localparam logic [5:0] IDX_CODE_B2 = 6'h18;
    localparam logic [5:0] IDX_MASK_B2 = 6'h1c;
    localparam logic [5:0] IDX_MASK_B2_LAST = 6'h1f;
    localparam logic [1:0] GRP_FILTER = 2'h1;
    localparam logic [1:0] GRP_RXBUF = 2'h2;
    localparam logic [1:0] GRP_TXBUF = 2'h3;
    // buffer layout
    localparam int BUF_BYTES = 16;
    localparam int MSG_BYTES = 13;
    localparam logic [3:0] OFS_IDENT0 = 4'h0;
    localparam logic [3:0] OFS_IDENT1 = 4'h1;
    localparam logic [3:0] OFS_PAYLOAD0 = 4'h4;
    localparam logic [3:0] OFS_LENGTH = 4'hc;
    localparam logic [3:0] OFS_PRIO = 4'hd;
    localparam logic [3:0] OFS_STAMP_HI = 4'he;
    localparam logic [3:0] OFS_STAMP_LO = 4'hf;
    localparam int IDE_BIT = 3;
    // control and status fields
    localparam int CTRL_INIT_REQUEST_BIT = 0;
    localparam int CTRL_TIME_BIT = 3;
    localparam int STAT_INIT_ACKNOWLEDGE_BIT = 0;
    localparam int STAT_RXF_BIT = 1;
    localparam int STAT_TXE_BIT = 2;
    localparam int SEL_TX0_BIT = 0;
    // reset values
    localparam logic [7:0] FILTER_RESET = 8'h00;
    localparam logic [7:0] PRIO_RESET = 8'h00;
    localparam logic [7:0] TXSEL_RESET = 8'h00;
    localparam logic TXE_RESET = 1'b1;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** testbench/canm_chk.sv ***
`default_nettype none
module canm_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic arvalid, arready, rvalid, rready,
    input wire logic [1:0] bresp,
    input wire logic [31:0] rdata,
    // frame side
    input wire logic rx_frame_valid, rx_full_out, tx_done, tx_request,
    input wire logic [31:0] tx_ident,
    input wire logic [7:0] tx_priority_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_wr_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    chk_rd_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
    chk_rdata_lane: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("read data beyond low byte");
    chk_ready_block: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");
    // a flag without a frame three edges back means a phantom accept
    chk_rx_signal: assert property ($rose(rx_full_out) |-> $past(rx_frame_valid, 3))
        else $error("receive flag without frame");
    chk_tx_drop: assert property (tx_request && tx_done |=> !tx_request)
        else $error("transmit request held after done");
    chk_tx_frozen: assert property (tx_request && $past(tx_request) && !tx_done
        |=> $stable(tx_ident) && $stable(tx_priority_out))
        else $error("transmit buffer changed while owned");
    cover property (bvalid && bready);
    cover property ($rose(rx_full_out));
    cover property (tx_done);
endmodule
bind canm_filter_buffers canm_chk u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
    .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .bresp, .rdata, .rx_frame_valid,
    .rx_full_out, .tx_done, .tx_request, .tx_ident, .tx_priority_out);
`default_nettype wire

// *** testbench/canm_engine_model.sv ***
`default_nettype none
module canm_engine_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // transmit handshake
    input wire logic tx_request,
    input wire logic [7:0] tx_wait,
    output logic tx_done,
    // received frame
    output logic rx_frame_valid,
    output logic [31:0] rx_ident,
    output logic [63:0] rx_payload,
    output logic [3:0] rx_length
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial begin
        tx_done = 1'b0;
        rx_frame_valid = 1'b0;
        rx_ident = 32'h0;
        rx_payload = 64'h0;
        rx_length = 4'h0;
    end
    // lines invert after the pulse so stale values never look valid
    task automatic send(input logic [31:0] id, input logic [63:0] p, input logic [3:0] n);
        @(posedge aclk);
        rx_frame_valid <= 1'b1;
        rx_ident <= id;
        rx_payload <= p;
        rx_length <= n;
        @(posedge aclk);
        rx_frame_valid <= 1'b0;
        rx_ident <= ~id;
        rx_payload <= ~p;
        rx_length <= ~n;
    endtask
    // transfer time set by the bench, short or long
    always @(posedge aclk) begin
        if (!aresetn || !tx_request || tx_done) begin
            cnt <= 0;
            tx_done <= 1'b0;
        end else begin
            cnt <= cnt + 1;
            tx_done <= (cnt == int'(tx_wait));
        end
    end
endmodule
`default_nettype wire

// *** testbench/test_can_accept_mask_msg_buffers.sv ***
`default_nettype none
module test_can_accept_mask_msg_buffers;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0] RXB = {canm_pkg::GRP_RXBUF, 4'h0};
    localparam logic [5:0] TXB = {canm_pkg::GRP_TXBUF, 4'h0};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, tx_wait = 8'h0c;
    logic [31:0] wdata = 32'h0;
    wire logic awready, wready, bvalid, arready, rvalid, rx_frame_valid, tx_done, tx_request;
    wire logic rx_full_out;
    wire logic [1:0] bresp, rresp;
    wire logic [3:0] rx_length, tx_length;
    wire logic [7:0] tx_priority_out;
    wire logic [31:0] rdata, rx_ident, tx_ident;
    wire logic [63:0] rx_payload, tx_payload;
    int fail_count = 0;
    int cmp_count = 0;
    int tcnt = 0;
    logic [15:0] tx_stamp = 16'h0000;
    logic [1:0] rd_resp = 2'h0;
    always #20 aclk = ~aclk;
    // mirrors the stamp timer: cleared in reset, one step per cycle
    always @(posedge aclk) begin
        tcnt <= aresetn ? tcnt + 1 : 0;
        if (tx_done) tx_stamp <= 16'(tcnt);
    end
    canm_filter_buffers dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
        .wdata, .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rx_frame_valid,
        .rx_ident, .rx_payload, .rx_length, .tx_done, .tx_request, .tx_ident, .tx_payload,
        .tx_length, .tx_priority_out, .rx_full_out);
    canm_engine_model eng (.aclk, .aresetn, .tx_request, .tx_wait, .tx_done, .rx_frame_valid,
        .rx_ident, .rx_payload, .rx_length);
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tmo();
        fail_count++;
        stop_test();
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [5:0] x, input logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= {x, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i <= 40; i++) begin
            if (i == 40) tmo();
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [5:0] x, output logic [31:0] d);
        @(posedge aclk);
        araddr <= {x, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i <= 40; i++) begin
            if (i == 40) tmo();
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                rd_resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rk(input logic [5:0] x, input logic [31:0] e);
        logic [31:0] d;
        rd(x, d);
        chk(d, e);
        chk({30'h0, rd_resp}, {30'h0, canm_pkg::RESP_OKAY});
    endtask
    task automatic wk(input logic [5:0] x, input logic [7:0] d);
        logic [1:0] r;
        wr(x, d, r);
        chk({30'h0, r}, {30'h0, canm_pkg::RESP_OKAY});
    endtask
    function automatic logic [7:0] byt(input logic [31:0] x, input int k);
        return x[8*(3-k)+:8];
    endfunction
    // standard frames compare only the upper two bytes
    function automatic bit hit(input logic [31:0] id, input logic [31:0] c, m);
        return ((((id ^ c) & ~m) >> (id[19] ? 0 : 16)) == 32'h0);
    endfunction
    initial begin
        logic [31:0] c1, m1, c2, id, v;
        logic [63:0] p;
        logic [3:0] n;
        logic [7:0] pr;
        logic [1:0] r;
        logic [15:0] st;
        bit acc;
        v = $urandom(32'h2ba1);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 4; k++) rk(canm_pkg::IDX_MASK_B2 + 6'(k), 32'h0);
        wr(6'h05, 8'h5a, r);
        chk({30'h0, r}, {30'h0, canm_pkg::RESP_SLVERR});
        wk(canm_pkg::IDX_MASK_B2, 8'hff);
        rk(canm_pkg::IDX_MASK_B2, 32'h0);
        $display("test reset_and_lock done");
        c1 = $urandom | 32'h00080000;
        m1 = ($urandom & 32'h7f7f7f7f) | 32'h00080000;
        c2 = $urandom;
        wk(canm_pkg::IDX_CTRL, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wk(canm_pkg::IDX_CODE_B1 + 6'(k), byt(c1, k));
            wk(canm_pkg::IDX_MASK_B1 + 6'(k), byt(m1, k));
            wk(canm_pkg::IDX_CODE_B2 + 6'(k), byt(c2, k));
            wk(canm_pkg::IDX_MASK_B2 + 6'(k), 8'h00);
            rk(canm_pkg::IDX_MASK_B1 + 6'(k), {24'h0, byt(m1, k)});
        end
        wk(canm_pkg::IDX_CTRL, 8'h08);
        wk(canm_pkg::IDX_MASK_B1, ~byt(m1, 0));
        rk(canm_pkg::IDX_MASK_B1, {24'h0, byt(m1, 0)});
        for (int k = 0; k < 4; k++) begin
            case (k)
                0: id = c1 ^ ($urandom & m1);
                1: id = c1 ^ 32'h80000000;
                2: id = {c1[31:16] ^ 16'($urandom & m1[31:16]), 16'($urandom)} & 32'hfff7ffff;
                default: id = $urandom;
            endcase
            p = {$urandom, $urandom};
            n = 4'($urandom);
            acc = hit(id, c1, m1) || hit(id, c2, 32'h0);
            eng.send(id, p, n);
            // capture lands one edge after the frame edge
            st = 16'(tcnt + 1);
            repeat (4) @(posedge aclk);
            chk({31'h0, rx_full_out}, {31'h0, acc});
            rk(canm_pkg::IDX_STATUS, {29'h0, 1'b1, acc, 1'b0});
            if (acc) begin
                rk(RXB, {24'h0, id[31:24]});
                rk(RXB + 6'h1, {24'h0, id[23:16]});
                rk(RXB + 6'h4, {24'h0, p[63:56]});
                rk(RXB + 6'hc, {28'h0, n});
                wk(RXB, ~id[31:24]);
                rk(RXB, {24'h0, id[31:24]});
                rk(RXB + 6'he, {24'h0, st[15:8]});
                rk(RXB + 6'hf, {24'h0, st[7:0]});
                wk(RXB + 6'he, ~st[15:8]);
                rk(RXB + 6'he, {24'h0, st[15:8]});
                wk(canm_pkg::IDX_STATUS, 8'h02);
            end else rk(RXB, 32'h0);
        end
        $display("test filter_and_receive done");
        wk(canm_pkg::IDX_TXSEL, 8'h01);
        for (int t = 0; t < 2; t++) begin
            id = $urandom;
            pr = 8'($urandom);
            if (t == 0) rk(TXB + 6'hd, 32'h0);
            for (int k = 0; k < 4; k++) wk(TXB + 6'(k), byt(id, k));
            p = {$urandom, $urandom};
            n = 4'($urandom);
            wk(TXB + 6'h4, p[63:56]);
            wk(TXB + 6'hc, {4'h0, n});
            wk(TXB + 6'hd, pr);
            tx_wait <= (t == 0) ? 8'd12 : 8'd40;
            wk(canm_pkg::IDX_STATUS, 8'h04);
            repeat (2) @(posedge aclk);
            chk({31'h0, tx_request}, 32'h1);
            chk(tx_ident, id);
            chk({24'h0, tx_priority_out}, {24'h0, pr});
            chk({24'h0, tx_payload[63:56]}, {24'h0, p[63:56]});
            chk({28'h0, tx_length}, {28'h0, n});
            rk(TXB, 32'h0);
            for (int i = 0; i <= 100 && tx_request !== 1'b0; i++) begin
                if (i == 100) tmo();
                @(posedge aclk);
            end
            rk(canm_pkg::IDX_STATUS, 32'h4);
            rk(TXB + 6'hd, {24'h0, pr});
            rk(TXB + 6'he, {24'h0, tx_stamp[15:8]});
            rk(TXB + 6'hf, {24'h0, tx_stamp[7:0]});
        end
        $display("test transmit done");
        stop_test();
    end
endmodule
`default_nettype wire
